// ---- srd_consts.svh ----
/*
  Offsets, field positions, reset values and timing counts of the SYSREF
  output state and delay block.
  Assumes inclusion by bare name; definitions only.
*/
`ifndef SRD_CONSTS_SVH
`define SRD_CONSTS_SVH

// ==========================================================================
// Register byte offsets
`define SRD_OFS_CTRL      12'h000
`define SRD_OFS_SREF_CFG  12'h004
`define SRD_OFS_ALIGN     12'h008
`define SRD_OFS_STATUS    12'h00C
`define SRD_OFS_CHAN_BASE 12'h010
`define SRD_OFS_REF_BASE  12'h040

// ==========================================================================
// Control register fields
`define SRD_CTRL_RELEASE  0
`define SRD_CTRL_STOP     1
`define SRD_CTRL_RESYNC   2
`define SRD_CTRL_CONT     3
`define SRD_CTRL_BIASTYPE 4

// ==========================================================================
// Per reference output fields
`define SRD_REF_FUNC      0
`define SRD_REF_PD        1
`define SRD_REF_EN        2
`define SRD_REF_BIAS      3
`define SRD_REF_SWING_LO  4
`define SRD_REF_COARSE_LO 6
`define SRD_REF_FINE_LO   9

// ==========================================================================
// Reset values and time units
`define SRD_RST_CHAN_DIV  8'h01
`define SRD_RST_SREF_DIV  13'h0040
`define SRD_RST_PULSES    8'h01
`define SRD_RST_ALIGN_DIV 7'h01
`define SRD_RST_SWING     2'h1
`define SRD_CLK_PS        407
`define SRD_COARSE_PS     203

`endif

// ---- srd_pkg.sv ----
/*
  Types of the SYSREF output state and delay block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none

package srd_pkg;

  // ========================================================================
  // SYSREF sequence states
  typedef enum logic [1:0] {
    SRD_IDLE  = 2'b00,
    SRD_ARM   = 2'b01,
    SRD_DELAY = 2'b10,
    SRD_PULSE = 2'b11
  } srd_state_t;

endpackage

`default_nettype wire

// ---- srd_top.sv ----
/*
  SYSREF output state machine, idle biasing, clock and SYSREF phase delay,
  release alignment divider, with an APB register slave.
  Assumes one clock (the VCO tick) and a synchronous active high reset;
  analog delay cells take the coarse and fine codes from the ports.
*/
// The address map and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "srd_consts.svh"

module srd_top #(
  parameter int N_CH  = 4,
  parameter int N_REF = 8
) (
  input  wire logic             clk_sys,
  input  wire logic             reset,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [11:0]      paddr,
  input  wire logic [31:0]      pwdata,
  output logic                  pready,
  output logic [31:0]           prdata,
  output logic                  pslverr,
  output logic [N_CH-1:0]       clk_output,
  output logic [N_REF-1:0]      ref_output_p,
  output logic [N_REF-1:0]      ref_output_n,
  output logic [N_REF-1:0]      ref_output_mid,
  output logic [N_REF-1:0]      ref_output_on,
  output logic [3*N_REF-1:0]    ref_coarse_code,
  output logic [3*N_REF-1:0]    ref_fine_code,
  output logic [2*N_REF-1:0]    ref_swing_code,
  output srd_pkg::srd_state_t   sysref_state
);
  import srd_pkg::*;

  // ========================================================================
  // Register storage
  logic [7:0]  chan_div_r   [N_CH];
  logic [7:0]  chan_dly_r   [N_CH];
  logic [11:0] ref_cfg_r    [N_REF];
  logic        cont_r;
  logic        bias_type_r;
  logic [12:0] sref_div_r;
  logic [7:0]  pulses_cfg_r;
  logic [6:0]  align_div_r;
  logic [7:0]  glob_dly_r;
  logic        release_r;
  logic        stop_r;
  logic        resync_r;

  logic        wr_en;
  logic        rd_en;
  logic [31:0] rdata_nxt;
  logic        err_nxt;

  // Register index decode for a per channel or per output window
  function automatic logic [7:0] win_idx(input logic [11:0] a,
                                         input logic [11:0] base);
    logic [11:0] d;
    d = a - base;
    return d[9:2];
  endfunction

  function automatic logic in_win(input logic [11:0] a,
                                  input logic [11:0] base, input int n);
    return (a >= base) && (a < base + 12'(4 * n)) && (a[1:0] == 2'b00);
  endfunction

  assign wr_en  = psel && penable && pwrite;
  assign rd_en  = psel && penable && !pwrite;
  assign pready = 1'b1;

  // ========================================================================
  // APB write side
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cont_r       <= 1'b0;
      bias_type_r  <= 1'b0;
      sref_div_r   <= `SRD_RST_SREF_DIV;
      pulses_cfg_r <= `SRD_RST_PULSES;
      align_div_r  <= `SRD_RST_ALIGN_DIV;
      glob_dly_r   <= 8'h00;
      for (int i = 0; i < N_CH; i++) begin
        chan_div_r[i] <= `SRD_RST_CHAN_DIV;
        chan_dly_r[i] <= 8'h00;
      end
      for (int i = 0; i < N_REF; i++) begin
        ref_cfg_r[i] <= {6'h00, `SRD_RST_SWING, 4'h0};
      end
    end else if (wr_en) begin
      if (paddr == `SRD_OFS_CTRL) begin
        cont_r      <= pwdata[`SRD_CTRL_CONT];
        bias_type_r <= pwdata[`SRD_CTRL_BIASTYPE];
      end
      if (paddr == `SRD_OFS_SREF_CFG) begin
        sref_div_r   <= pwdata[12:0];
        pulses_cfg_r <= pwdata[23:16];
      end
      if (paddr == `SRD_OFS_ALIGN) begin
        align_div_r <= pwdata[6:0];
        glob_dly_r  <= pwdata[15:8];
      end
      for (int i = 0; i < N_CH; i++) begin
        if (in_win(paddr, `SRD_OFS_CHAN_BASE, N_CH) &&
            win_idx(paddr, `SRD_OFS_CHAN_BASE) == 8'(i)) begin
          chan_div_r[i] <= pwdata[7:0];
          chan_dly_r[i] <= pwdata[15:8];
        end
      end
      for (int i = 0; i < N_REF; i++) begin
        if (in_win(paddr, `SRD_OFS_REF_BASE, N_REF) &&
            win_idx(paddr, `SRD_OFS_REF_BASE) == 8'(i)) begin
          ref_cfg_r[i] <= pwdata[11:0];
        end
      end
    end
  end

  // Command strobes, one cycle each
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      release_r <= 1'b0;
      stop_r    <= 1'b0;
      resync_r  <= 1'b0;
    end else begin
      release_r <= wr_en && paddr == `SRD_OFS_CTRL &&
                   pwdata[`SRD_CTRL_RELEASE];
      stop_r    <= wr_en && paddr == `SRD_OFS_CTRL &&
                   pwdata[`SRD_CTRL_STOP];
      resync_r  <= wr_en && paddr == `SRD_OFS_CTRL &&
                   pwdata[`SRD_CTRL_RESYNC];
    end
  end

  // ========================================================================
  // SYSREF sequence state
  srd_state_t  state_r;
  logic [6:0]  align_cnt_r;
  logic [7:0]  dly_cnt_r;
  logic [12:0] ns_cnt_r;
  logic [7:0]  pulse_left_r;
  logic        sref_lvl;
  logic        align_hit;
  logic        last_pulse;

  // ========================================================================
  // APB read side
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    err_nxt   = 1'b0;
    if (paddr == `SRD_OFS_CTRL) begin
      rdata_nxt[`SRD_CTRL_CONT]     = cont_r;
      rdata_nxt[`SRD_CTRL_BIASTYPE] = bias_type_r;
    end else if (paddr == `SRD_OFS_SREF_CFG) begin
      rdata_nxt = {8'h00, pulses_cfg_r, 3'h0, sref_div_r};
    end else if (paddr == `SRD_OFS_ALIGN) begin
      rdata_nxt = {16'h0000, glob_dly_r, 1'b0, align_div_r};
    end else if (paddr == `SRD_OFS_STATUS) begin
      rdata_nxt = {22'h00_0000, pulse_left_r, state_r};
    end else if (in_win(paddr, `SRD_OFS_CHAN_BASE, N_CH)) begin
      for (int i = 0; i < N_CH; i++) begin
        if (win_idx(paddr, `SRD_OFS_CHAN_BASE) == 8'(i)) begin
          rdata_nxt = {16'h0000, chan_dly_r[i], chan_div_r[i]};
        end
      end
    end else if (in_win(paddr, `SRD_OFS_REF_BASE, N_REF)) begin
      for (int i = 0; i < N_REF; i++) begin
        if (win_idx(paddr, `SRD_OFS_REF_BASE) == 8'(i)) begin
          rdata_nxt = {20'h0_0000, ref_cfg_r[i]};
        end
      end
    end else begin
      err_nxt = 1'b1;
    end
  end

  always_comb begin
    prdata  = rd_en ? rdata_nxt : 32'h0000_0000;
    pslverr = psel && penable && err_nxt;
  end

  // ========================================================================
  // Release alignment divider
  always_ff @(posedge clk_sys) begin
    if (reset || resync_r) begin
      align_cnt_r <= 7'h00;
    end else if (align_cnt_r + 7'h01 >= align_div_r) begin
      align_cnt_r <= 7'h00;
    end else begin
      align_cnt_r <= align_cnt_r + 7'h01;
    end
  end

  assign align_hit = (align_cnt_r == 7'h00);

  // ========================================================================
  // SYSREF sequencer
  assign sref_lvl   = (ns_cnt_r < (sref_div_r >> 1));
  assign last_pulse = (ns_cnt_r + 13'h0001 >= sref_div_r);

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_r      <= SRD_IDLE;
      dly_cnt_r    <= 8'h00;
      ns_cnt_r     <= 13'h0000;
      pulse_left_r <= 8'h00;
    end else if (stop_r) begin
      state_r <= SRD_IDLE;
    end else begin
      unique case (state_r)
        SRD_IDLE: begin
          if (release_r && (cont_r || pulses_cfg_r != 8'h00)) begin
            state_r      <= SRD_ARM;
            pulse_left_r <= pulses_cfg_r;
          end
        end
        SRD_ARM: begin
          if (align_hit) begin
            state_r   <= (glob_dly_r == 8'h00) ? SRD_PULSE : SRD_DELAY;
            dly_cnt_r <= glob_dly_r;
            ns_cnt_r  <= 13'h0000;
          end
        end
        SRD_DELAY: begin
          dly_cnt_r <= dly_cnt_r - 8'h01;
          if (dly_cnt_r == 8'h01) begin
            state_r <= SRD_PULSE;
          end
        end
        SRD_PULSE: begin
          if (last_pulse) begin
            ns_cnt_r <= 13'h0000;
            if (!cont_r) begin
              pulse_left_r <= pulse_left_r - 8'h01;
              if (pulse_left_r == 8'h01) begin
                state_r <= SRD_IDLE;
              end
            end
          end else begin
            ns_cnt_r <= ns_cnt_r + 13'h0001;
          end
        end
      endcase
    end
  end

  assign sysref_state = state_r;

  // ========================================================================
  // Channel clock dividers with phase delay
  logic [N_CH-1:0] chan_clk;

  generate
    for (genvar c = 0; c < N_CH; c++) begin : g_chan
      logic [7:0] hold_r;
      logic [7:0] cnt_r;
      logic [7:0] half;
      logic [8:0] div_p1;
      assign div_p1 = {1'b0, chan_div_r[c]} + 9'h001;
      assign half   = div_p1[8:1];
      // Counters restart together; after a resync each channel holds for its chan_dly_r cycles (no hold after reset), so rising edges are offset by that delay
      always_ff @(posedge clk_sys) begin
        if (reset || resync_r) begin
          hold_r <= reset ? 8'h00 : chan_dly_r[c];
          cnt_r  <= 8'h00;
        end else if (hold_r != 8'h00) begin
          hold_r <= hold_r - 8'h01;
        end else if (cnt_r + 8'h01 >= chan_div_r[c]) begin
          cnt_r <= 8'h00;
        end else begin
          cnt_r <= cnt_r + 8'h01;
        end
      end
      assign chan_clk[c] = (hold_r == 8'h00) && (cnt_r < half);
      always_ff @(posedge clk_sys) begin
        if (reset) begin
          clk_output[c] <= 1'b0;
        end else begin
          clk_output[c] <= chan_clk[c];
        end
      end
    end
  endgenerate

  // ========================================================================
  // Reference output drive
  generate
    for (genvar r = 0; r < N_REF; r++) begin : g_ref
      logic func;
      logic pd;
      logic en;
      logic bias;
      logic act;
      logic p_nxt;
      logic mid_nxt;
      logic on_nxt;
      assign func = ref_cfg_r[r][`SRD_REF_FUNC];
      assign pd   = ref_cfg_r[r][`SRD_REF_PD];
      assign en   = ref_cfg_r[r][`SRD_REF_EN];
      assign bias = ref_cfg_r[r][`SRD_REF_BIAS];
      assign act  = (state_r == SRD_PULSE) && !bias;
      always_comb begin
        p_nxt   = 1'b0;
        mid_nxt = 1'b0;
        on_nxt  = 1'b0;
        if (pd) begin
          on_nxt = 1'b0;
        end else if (!func) begin
          on_nxt = 1'b1;
          p_nxt  = en && chan_clk[r % N_CH];
        end else if (act) begin
          on_nxt = 1'b1;
          p_nxt  = sref_lvl;
        end else begin
          on_nxt  = bias_type_r;
          mid_nxt = bias_type_r;
        end
      end
      always_ff @(posedge clk_sys) begin
        if (reset) begin
          ref_output_p[r]   <= 1'b0;
          ref_output_n[r]   <= 1'b1;
          ref_output_mid[r] <= 1'b0;
          ref_output_on[r]  <= 1'b0;
        end else begin
          ref_output_p[r]   <= p_nxt && !mid_nxt;
          ref_output_n[r]   <= !p_nxt && !mid_nxt;
          ref_output_mid[r] <= mid_nxt;
          ref_output_on[r]  <= on_nxt;
        end
      end
      always_ff @(posedge clk_sys) begin
        if (reset) begin
          ref_coarse_code[3*r +: 3] <= 3'h0;
          ref_fine_code[3*r +: 3]   <= 3'h0;
          ref_swing_code[2*r +: 2]  <= `SRD_RST_SWING;
        end else begin
          ref_coarse_code[3*r +: 3] <=
            ref_cfg_r[r][`SRD_REF_COARSE_LO +: 3];
          ref_fine_code[3*r +: 3]   <=
            ref_cfg_r[r][`SRD_REF_FINE_LO +: 3];
          ref_swing_code[2*r +: 2]  <= ref_cfg_r[r][`SRD_REF_SWING_LO +: 2];
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

// ---- srd_top_monitor.sv ----
/* Port checker for srd_top.
   Assumes one clock and a synchronous active high reset. */
`timescale 1ns/1ps
`default_nettype none
module srd_top_monitor #(
  parameter int N_REF = 8
) (
  input wire logic                clk_sys,
  input wire logic                reset,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic                pslverr,
  input wire logic [N_REF-1:0]    ref_output_p,
  input wire logic [N_REF-1:0]    ref_output_n,
  input wire logic [N_REF-1:0]    ref_output_mid,
  input wire logic [N_REF-1:0]    ref_output_on,
  input wire logic [3*N_REF-1:0]  ref_coarse_code,
  input wire logic [3*N_REF-1:0]  ref_fine_code,
  input wire logic [2*N_REF-1:0]  ref_swing_code,
  input wire srd_pkg::srd_state_t sysref_state
);
  import srd_pkg::*;
  // ==================
  // Port relations
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  property p_rst_codes;
    $fell(reset) |-> {ref_coarse_code, ref_fine_code} == '0;
  endproperty
  a_rst_codes: assert property (p_rst_codes) else $error("codes");
  property p_codes_hold;
    !(psel && penable && pwrite) && !$past(psel && penable && pwrite) |=>
      $stable({ref_coarse_code, ref_fine_code, ref_swing_code});
  endproperty
  a_codes_hold: assert property (p_codes_hold) else $error("hold");
  property p_off_low; (~ref_output_on & (ref_output_p | ~ref_output_n)) == '0;
  endproperty
  a_off_low: assert property (p_off_low) else $error("off legs");
  property p_mid_legs; (ref_output_mid & (ref_output_p | ref_output_n)) == '0;
  endproperty
  a_mid_legs: assert property (p_mid_legs) else $error("mid legs");
  property p_mid_on; (ref_output_mid & ~ref_output_on) == '0; endproperty
  a_mid_on: assert property (p_mid_on) else $error("mid off");
  property p_legs;
    (ref_output_on & ~ref_output_mid & ~(ref_output_p ^ ref_output_n)) == '0;
  endproperty
  a_legs: assert property (p_legs) else $error("legs equal");
  property p_idle_exit;
    sysref_state == SRD_IDLE ##1 sysref_state != SRD_IDLE
      |-> sysref_state == SRD_ARM;
  endproperty
  a_idle_exit: assert property (p_idle_exit) else $error("idle exit");
  property p_arm_bound;
    sysref_state == SRD_ARM |-> ##[1:128] sysref_state != SRD_ARM;
  endproperty
  a_arm_bound: assert property (p_arm_bound) else $error("arm long");
  c_pulse: cover property (sysref_state == SRD_PULSE);
  c_mid: cover property (ref_output_mid != '0);
  c_err: cover property (psel && penable && pslverr);
endmodule
bind srd_top srd_top_monitor #(.N_REF(N_REF)) srd_top_monitor_inst (
  .clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pslverr(pslverr), .ref_output_p(ref_output_p),
  .ref_output_n(ref_output_n), .ref_output_mid(ref_output_mid),
  .ref_output_on(ref_output_on), .ref_coarse_code(ref_coarse_code),
  .ref_fine_code(ref_fine_code), .ref_swing_code(ref_swing_code),
  .sysref_state(sysref_state));
`default_nettype wire

// ---- srd_conv_model.sv ----
/* Converter stand-in: counts rising edges on each driven output.
   Assumes outputs registered on clk_sys. */
`timescale 1ns/1ps
`default_nettype none
module srd_conv_model #(
  parameter int N_REF = 8
) (
  input wire logic             clk_sys,
  input wire logic             clr,
  input wire logic [N_REF-1:0] ref_output_p,
  input wire logic [N_REF-1:0] ref_output_on,
  output logic [7:0]           rise_cnt [N_REF]
);
  logic [N_REF-1:0] prev_r;
  // ==================
  // Edge capture
  always_ff @(posedge clk_sys) begin
    prev_r <= ref_output_p;
    for (int r = 0; r < N_REF; r++) begin
      if (clr) begin
        rise_cnt[r] <= 8'h00;
      end else if (ref_output_on[r] && ref_output_p[r] && !prev_r[r]) begin
        rise_cnt[r] <= rise_cnt[r] + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// ---- srd_top_tb_top.sv ----
/* Self-checking bench of srd_top.
   Assumes the checker binds itself. */
`timescale 1ns/1ps
`default_nettype none
`include "srd_consts.svh"
module srd_top_tb_top;
  import srd_pkg::*;
  logic        clk_sys = 1'b0;
  logic        reset   = 1'b1;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic        clr     = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic        pready;
  logic        pslverr;
  logic [31:0] prdata;
  logic [3:0]  clk_output;
  logic [7:0]  ref_output_p;
  logic [7:0]  ref_output_n;
  logic [7:0]  ref_output_mid;
  logic [7:0]  ref_output_on;
  logic [23:0] ref_coarse_code;
  logic [23:0] ref_fine_code;
  logic [15:0] ref_swing_code;
  srd_state_t  sysref_state;
  logic [7:0]  rise_cnt [8];
  logic [31:0] word;
  logic [32:0] exp_q [$];
  logic [32:0] exp_e;
  int          mismatches = 0;
  int          n_compared = 0;
  int          cyc = 0;
  localparam logic [3:0] CFG [8] = '{4'h5, 4'hD, 4'h3, 4'h4,
                                     4'h5, 4'h5, 4'h5, 4'h5};
  srd_top srd_top_inst (.clk_sys(clk_sys), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .clk_output(clk_output), .ref_output_p(ref_output_p),
    .ref_output_n(ref_output_n), .ref_output_mid(ref_output_mid),
    .ref_output_on(ref_output_on), .ref_coarse_code(ref_coarse_code),
    .ref_fine_code(ref_fine_code), .ref_swing_code(ref_swing_code),
    .sysref_state(sysref_state));
  srd_conv_model srd_conv_model_inst (.clk_sys(clk_sys), .clr(clr),
    .ref_output_p(ref_output_p), .ref_output_on(ref_output_on),
    .rise_cnt(rise_cnt));
  always #2 clk_sys = ~clk_sys;
  // ==================
  // Tasks
  task automatic tally_and_finish();
    $display("Compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] ex,
                     input logic [31:0] got);
    n_compared++;
    if (got !== ex) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] ex);
    exp_q.push_back(ex);
    apb(1'b0, a, 32'h0000_0000);
  endtask
  task automatic wait_st(input srd_state_t s);
    for (int n = 0; n < 400 && sysref_state !== s; n++) @(posedge clk_sys);
    chk("state", 32'(s), 32'(sysref_state));
  endtask
  task automatic run_event(input logic [31:0] ctl, input logic bt);
    int n;
    n = 0;
    clr <= 1'b1;
    apb(1'b1, `SRD_OFS_CTRL, ctl);
    clr <= 1'b0;
    wait_st(SRD_DELAY);
    for (; n < 300 && sysref_state === SRD_DELAY; n++) @(posedge clk_sys);
    chk("delay", 32'd2, 32'(n));
    repeat (2) @(posedge clk_sys);
    chk("on_pulse", 32'h1, 32'(ref_output_on[0]));
    wait_st(SRD_IDLE);
    repeat (3) @(posedge clk_sys);
    chk("pulses", 32'h3, 32'(rise_cnt[0]));
    chk("bias_quiet", 32'h0, 32'(rise_cnt[1]));
    chk("pd_quiet", 32'h0, 32'(rise_cnt[2]));
    chk("pd_off", 32'h0, 32'(ref_output_on[2]));
    chk("clk_copy", 32'h1, 32'(rise_cnt[3] != 8'h00));
    chk("idle_on", 32'(bt), 32'(ref_output_on[0]));
    chk("idle_mid", 32'({bt, bt}), 32'(ref_output_mid[1:0]));
  endtask
  // ==================
  // Read result watcher and timeout
  always @(posedge clk_sys) begin
    if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
      exp_e = exp_q.pop_front();
      chk("prdata", exp_e[31:0], prdata);
      chk("pslverr", 32'(exp_e[32]), 32'(pslverr));
    end
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 6000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  // ==================
  // Main sequence
  initial begin
    void'($urandom(98));
    repeat (16) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    chk("swing_rst", 32'h0000_5555, 32'(ref_swing_code));
    rd(`SRD_OFS_ALIGN, 33'h0_0000_0001);
    rd(`SRD_OFS_CHAN_BASE, 33'h0_0000_0001);
    rd(12'h0FC, 33'h1_0000_0000);
    for (int r = 0; r < 8; r++) begin
      word = {20'h0_0000, 6'($urandom()), 2'b01, CFG[r]};
      apb(1'b1, `SRD_OFS_REF_BASE + 12'(4 * r), word);
      rd(`SRD_OFS_REF_BASE + 12'(4 * r), {1'b0, word});
      chk("coarse", 32'(word[8:6]), 32'(ref_coarse_code[3*r+:3]));
      chk("fine", 32'(word[11:9]), 32'(ref_fine_code[3*r+:3]));
    end
    apb(1'b1, `SRD_OFS_CHAN_BASE + 12'h008, 32'h0000_0102);
    apb(1'b1, `SRD_OFS_CHAN_BASE + 12'h00C, 32'h0000_0002);
    rd(`SRD_OFS_CHAN_BASE + 12'h008, 33'h0_0000_0102);
    apb(1'b1, `SRD_OFS_CTRL, 32'h0000_0004);
    repeat (6) @(posedge clk_sys);
    for (int i = 0; i < 4; i++) begin
      chk("invert", 32'(!clk_output[3]), 32'(clk_output[2]));
      @(posedge clk_sys);
    end
    apb(1'b1, `SRD_OFS_ALIGN, 32'h0000_0202);
    apb(1'b1, `SRD_OFS_SREF_CFG, 32'h0003_0008);
    run_event(32'h0000_0001, 1'b0);
    apb(1'b1, `SRD_OFS_CTRL, 32'h0000_0010);
    repeat (3) @(posedge clk_sys);
    chk("cross_idle", 32'h3, 32'(ref_output_mid[1:0]));
    run_event(32'h0000_0011, 1'b1);
    apb(1'b1, `SRD_OFS_CTRL, 32'h0000_0009);
    wait_st(SRD_PULSE);
    repeat (40) @(posedge clk_sys);
    chk("cont_run", 32'(SRD_PULSE), 32'(sysref_state));
    rd(`SRD_OFS_STATUS, 33'h0_0000_000F);
    apb(1'b1, `SRD_OFS_CTRL, 32'h0000_0002);
    wait_st(SRD_IDLE);
    repeat (3) @(posedge clk_sys);
    chk("stop_off", 32'h0, 32'(ref_output_on[0]));
    tally_and_finish();
  end
endmodule
`default_nettype wire
